// *** verification/dct_chk.sv ***
`timescale 1ns/1ps
module dct_chk (
  // clock and reset
  input wire logic        mclk_in,
  input wire logic        reset_n_in,
  // channel side
  input wire logic        req_ack_out,
  input wire logic [7:0]  req_code_out,
  input wire logic        mem_rd_out,
  input wire logic [23:0] mem_addr_out,
  input wire logic        mem_ack_in,
  input wire logic        byte_done_out,
  input wire logic [1:0]  dest_step_out,
  input wire logic        block_done_out,
  input wire logic        busy_out
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);

  dest_hold_a: assert property (
    busy_out && $past(busy_out) |-> $stable(dest_step_out))
    else $error("dest step changed while busy");
  hw_code_a: assert property (
    req_ack_out |-> busy_out && req_code_out != 8'h00)
    else $error("hardware start with trigger code zero");
  rd_start_a: assert property (
    $rose(busy_out) |-> mem_rd_out)
    else $error("block start without read");
  byte_ack_a: assert property (
    1'b1 |=> byte_done_out == $past(mem_ack_in && mem_rd_out))
    else $error("byte done not tied to read ack");
  rd_hold_a: assert property (
    mem_rd_out && !mem_ack_in |=> mem_rd_out)
    else $error("read dropped before ack");
  addr_hold_a: assert property (
    mem_rd_out && !mem_ack_in |=> $stable(mem_addr_out))
    else $error("source address moved without ack");
  blk_end_a: assert property (
    byte_done_out |=> block_done_out == !$past(mem_rd_out))
    else $error("block end not after last byte");
  idle_rd_a: assert property (
    !busy_out |-> !mem_rd_out)
    else $error("read while idle");
  done_pulse_a: assert property (
    block_done_out |=> !block_done_out)
    else $error("block done longer than one cycle");
  end_busy_a: assert property (
    $fell(busy_out) |-> block_done_out)
    else $error("busy ended without block done");
endmodule : dct_chk

// *** verification/dct_mem_model.sv ***
`timescale 1ns/1ps
module dct_mem_model (
  // clock and reset
  input  wire logic       mclk_in,
  input  wire logic       reset_n_in,
  // byte read request and answer
  input  wire logic       mem_rd_in,
  input  wire logic [2:0] lat_in,
  output logic            mem_ack_out
);
  logic [2:0] wait_q;
  // one ack pulse per byte; a dropped read restarts the wait
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in || !mem_rd_in || mem_ack_out) begin
      wait_q      <= 3'h0;
      mem_ack_out <= 1'b0;
    end else if (wait_q >= lat_in) begin
      mem_ack_out <= 1'b1;
    end else begin
      wait_q <= wait_q + 3'h1;
    end
  end
endmodule : dct_mem_model

// *** verification/dma_channel_trigger_count_addr_bench.sv ***
`timescale 1ns/1ps
`define CHK(n, e, s) \
  begin \
    checks_done++; \
    if ((s) !== (e)) begin \
      n_errors++; \
      $display("wrong value %s exp %0h got %0h", n, e, s); \
    end \
  end
module dma_channel_trigger_count_addr_bench;
  import dct_pkg::*;
  // ****************************************************
  // signals
  // ****************************************************
  logic          mclk_in = 1'b0, reset_n_in = 1'b0;
  logic          hsel_in = 1'b0, hwrite_in = 1'b0;
  logic [31:0]   haddr_in = 32'h0, hwdata_in = 32'h0;
  logic [1:0]    htrans_in = 2'h0;
  logic [2:0]    hsize_in = 3'h2, lat = 3'h1;
  logic          req_irq_en_in = 1'b0;
  dct_trig_req_t trig_req_in = '0;
  wire logic     hready_in;
  logic          hreadyout_out, hresp_out, req_ack_out, mem_rd_out;
  logic          mem_ack_in, byte_done_out, block_done_out, busy_out;
  logic [31:0]   hrdata_out, e_v;
  logic [7:0]    req_code_out;
  logic [23:0]   mem_addr_out;
  logic [1:0]    dest_step_out;
  logic [31:0]   exp_rd [$];
  logic [7:0]    exp_code [$];
  logic [23:0]   exp_addr [$];
  int            n_errors = 0, checks_done = 0, cyc = 0;
  logic          rd_ph = 1'b0;
  logic [1:0]    mv [3] = '{2'h1, 2'h2, 2'h0};
  // codes are base plus offset; hb is the flag bit behind each
  logic [7:0] hc [22] = '{8'h01, 8'h03, 8'h04, 8'h10, 8'h14,
    8'h15, 8'h16, 8'h23, 8'h24, 8'h25, 8'h40, 8'h45, 8'h47, 8'h49,
    8'h4A, 8'h4B, 8'h4C, 8'h4E, 8'h4F, 8'h62, 8'h6F, 8'h8A};
  int hb [22] = '{0, 2, 3, 4, 6, 8, 9, 13, 10, 14, 16, 21, 23, 25,
    26, 27, 28, 29, 30, 33, 45, 56};
  // codes with no module behind them; port group four is left out
  logic [7:0] nc [8] = '{8'h00, 8'h05, 8'h17, 8'h27, 8'h4D, 8'h50,
    8'hA0, 8'hAB};

  assign hready_in = hreadyout_out;
  dct_channel #(.PORT_PRESENT(4'h7)) dut (.mclk_in, .reset_n_in,
    .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in,
    .hwdata_in, .hready_in, .hreadyout_out, .hresp_out, .hrdata_out,
    .trig_req_in, .req_irq_en_in, .req_ack_out, .req_code_out,
    .mem_rd_out, .mem_addr_out, .mem_ack_in, .byte_done_out,
    .dest_step_out, .block_done_out, .busy_out);
  dct_mem_model far (.mclk_in, .reset_n_in, .mem_rd_in(mem_rd_out),
    .lat_in(lat), .mem_ack_out(mem_ack_in));

  // ****************************************************
  // clock, timeout and result watcher
  // ****************************************************
  initial begin
    forever #25 mclk_in = ~mclk_in;
  end
  // a hang ends the run rather than the simulator limit
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      end_sim();
    end
  end
  // reads and codes are matched against the oldest note; addresses only while notes remain
  always @(posedge mclk_in) begin
    if (rd_ph && hreadyout_out === 1'b1) begin
      e_v = exp_rd.pop_front();
      `CHK("read data", e_v, hrdata_out)
      `CHK("response", 1'b0, hresp_out)
    end
    if (hreadyout_out === 1'b1)
      rd_ph = hsel_in && htrans_in[1] && !hwrite_in;
    if (req_ack_out === 1'b1) begin
      e_v = exp_code.size() > 0 ? exp_code.pop_front() : 32'hFFFFFFFF;
      `CHK("trigger code", e_v, {24'h0, req_code_out})
    end
    if (mem_ack_in && mem_rd_out === 1'b1 && exp_addr.size() > 0) begin
      e_v = {8'h0, exp_addr.pop_front()};
      `CHK("source address", e_v, {8'h0, mem_addr_out})
    end
  end

  // ****************************************************
  // tasks
  // ****************************************************
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [7:0] d);
    hsel_in   <= 1'b1;
    htrans_in <= 2'h2;
    haddr_in  <= {22'h0, idx, 2'h0};
    hwrite_in <= wr;
    do @(posedge mclk_in); while (hreadyout_out !== 1'b1);
    hsel_in   <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= {24'h0, d};
    do @(posedge mclk_in); while (hreadyout_out !== 1'b1);
  endtask : bus
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    exp_rd.push_back({24'h0, e});
    bus(1'b0, idx, 8'h00);
  endtask : rd
  task automatic wblk();
    int i;
    for (i = 0; i < 400; i++) begin
      @(posedge mclk_in);
      if (block_done_out === 1'b1) break;
    end
    `CHK("block done", 1'b1, block_done_out)
  endtask : wblk
  task automatic no_start(input logic [7:0] code);
    bus(1'b1, IDX_TRIG, code);
    bus(1'b1, IDX_CTRL, 8'h80);
    repeat (20) @(posedge mclk_in);
    `CHK("busy", 1'b0, busy_out)
    bus(1'b1, IDX_CTRL, 8'h00);
  endtask : no_start
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim

  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin : main
    int k;
    logic [23:0] sa;
    logic [7:0] v;
    void'($urandom(32'h7604));
    repeat (4) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    @(posedge mclk_in);
    // reset values, unmapped word, random readback
    bus(1'b1, 8'h07, 8'h5A);
    rd(8'h07, 8'h00);
    rd(IDX_ADDRCTRL, 8'h00);
    rd(IDX_CNTL, 8'hFF);
    rd(IDX_CNTH, 8'h00);
    rd(IDX_SA2, 8'h00);
    v = 8'($urandom);
    bus(1'b1, IDX_TRIG, v);
    rd(IDX_TRIG, v);
    v = 8'($urandom);
    bus(1'b1, IDX_REP, v);
    rd(IDX_REP, v);
    $display("test registers done");
    // stepping modes, busy-time writes ignored or held
    bus(1'b1, IDX_REP, 8'h00);
    bus(1'b1, IDX_CNTL, 8'h03);
    bus(1'b1, IDX_CNTH, 8'h00);
    bus(1'b1, IDX_SA0, 8'h56);
    bus(1'b1, IDX_SA1, 8'h34);
    bus(1'b1, IDX_SA2, 8'h12);
    sa = 24'h123456;
    for (k = 0; k < 3; k++) begin
      bus(1'b1, IDX_ADDRCTRL, {2'h0, mv[k], 2'h0, mv[k]});
      repeat (3) begin
        exp_addr.push_back(sa);
        sa = mv[k] == 2'h1 ? sa + 24'h1 : mv[k] == 2'h2 ? sa - 24'h1 : sa;
      end
      lat <= 3'($urandom);
      bus(1'b1, IDX_CTRL, 8'h90);
      if (k == 0) begin
        bus(1'b1, IDX_ADDRCTRL, 8'h33);
        bus(1'b1, IDX_SA0, 8'hAA);
      end
      wblk();
      `CHK("dest step", mv[k], dest_step_out)
      rd(IDX_ADDRCTRL, {2'h0, mv[k], 2'h0, mv[k]});
      rd(IDX_CNTL, 8'h03);
      rd(IDX_CTRL, 8'h00);
    end
    $display("test address stepping done");
    // a blocked request, then every request kind, then absent ones
    bus(1'b1, IDX_CNTL, 8'h01);
    bus(1'b1, IDX_CNTH, 8'h00);
    req_irq_en_in <= 1'b1;
    trig_req_in[0] <= 1'b1;
    no_start(TRG_EVT);
    req_irq_en_in <= 1'b0;
    trig_req_in <= '0;
    for (k = 0; k < 22; k++) begin
      bus(1'b1, IDX_TRIG, hc[k]);
      bus(1'b1, IDX_CTRL, 8'h80);
      exp_code.push_back(hc[k]);
      trig_req_in[hb[k]] <= 1'b1;
      wblk();
      trig_req_in <= '0;
    end
    trig_req_in <= '1;
    for (k = 0; k < 8; k++)
      no_start(nc[k]);
    trig_req_in <= '0;
    $display("test trigger codes done");
    // limited and unlimited repeat
    bus(1'b1, IDX_TRIG, TRG_EVT);
    bus(1'b1, IDX_REP, 8'h02);
    repeat (2) exp_code.push_back(TRG_EVT);
    trig_req_in[0] <= 1'b1;
    bus(1'b1, IDX_CTRL, 8'hA0);
    repeat (2) wblk();
    repeat (20) @(posedge mclk_in);
    rd(IDX_REP, 8'h00);
    rd(IDX_CTRL, 8'h20);
    bus(1'b1, IDX_REP, 8'h00);
    repeat (4) exp_code.push_back(TRG_EVT);
    bus(1'b1, IDX_CTRL, 8'hA0);
    repeat (3) wblk();
    trig_req_in <= '0;
    wblk();
    rd(IDX_CTRL, 8'hA0);
    bus(1'b1, IDX_CTRL, 8'h00);
    $display("test repeat done");
    // zero count becomes all ones; slow memory keeps the first
    // byte away, and a mid-run reset ends the long block
    lat <= 3'h7;
    bus(1'b1, IDX_CNTL, 8'h00);
    bus(1'b1, IDX_CNTH, 8'h00);
    bus(1'b1, IDX_CTRL, 8'h90);
    rd(IDX_CNTL, 8'hFF);
    rd(IDX_CNTH, 8'hFF);
    rd(IDX_STAT, 8'h80);
    reset_n_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    @(posedge mclk_in);
    `CHK("busy", 1'b0, busy_out)
    rd(IDX_CNTL, 8'hFF);
    rd(IDX_CTRL, 8'h00);
    $display("test zero count done");
    end_sim();
  end
endmodule : dma_channel_trigger_count_addr_bench

bind dct_channel dct_chk chk (.mclk_in, .reset_n_in, .req_ack_out,
  .req_code_out, .mem_rd_out, .mem_addr_out, .mem_ack_in,
  .byte_done_out, .dest_step_out, .block_done_out, .busy_out);

// *** verilog/dct_channel.sv ***
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
module dct_channel #(
  // present modules: evt, aes, adc1, dac1, adc2, dac2
  parameter logic [5:0] MOD_PRESENT  = 6'h3F,
  parameter logic [3:0] PORT_PRESENT = 4'hF
)(
  // clock and reset
  input  wire logic                 mclk_in,
  input  wire logic                 reset_n_in,
  // ahb-lite slave
  input  wire logic                 hsel_in,
  input  wire logic [31:0]          haddr_in,
  input  wire logic [1:0]           htrans_in,
  input  wire logic                 hwrite_in,
  input  wire logic [2:0]           hsize_in,
  input  wire logic [31:0]          hwdata_in,
  input  wire logic                 hready_in,
  output logic                      hreadyout_out,
  output logic                      hresp_out,
  output logic [31:0]               hrdata_out,
  // peripheral requests
  input  wire dct_pkg::dct_trig_req_t trig_req_in,
  input  wire logic                 req_irq_en_in,
  output logic                      req_ack_out,
  output logic [7:0]                req_code_out,
  // memory read side
  output logic                      mem_rd_out,
  output logic [23:0]               mem_addr_out,
  input  wire logic                 mem_ack_in,
  // channel status
  output logic                      byte_done_out,
  output logic [1:0]                dest_step_out,
  output logic                      block_done_out,
  output logic                      busy_out
);
  import dct_pkg::*;

  // ****************************************************
  // declarations
  // ****************************************************
  logic        ap_q, ap_wr_q, ap_ok_q, rd_wait_q;
  logic [7:0]  ap_idx_q;
  logic [7:0]  hrdata_q, rd_val, wdata;
  logic        take, wr_en;
  logic        en_q, rep_mode_q, sw_pend_q;
  dct_step_t   src_step_q, dst_step_q;
  logic [7:0]  trig_q, rep_q, cnt_tmp_q, cnt_hold_q;
  logic [15:0] cnt_q, cnt_rl_q, sa_tmp_q;
  logic [23:0] sa_q;
  dct_state_t  state_q;
  logic        hw_req, start, rd_ack, idle;
  logic        ack_q, byte_q, blk_q;
  logic [7:0]  code_q;

  // ****************************************************
  // helpers
  // ****************************************************
  // one strobe per register write in the data phase
  function automatic logic wr(input logic [7:0] idx);
    wr = wr_en && (ap_idx_q == idx);
  endfunction : wr

  // address step; the reserved code holds the address
  function automatic logic [23:0] step_addr(input logic [23:0] a,
                                            input dct_step_t m);
    case (m)
      STEP_INC: step_addr = a + 24'h000001;
      STEP_DEC: step_addr = a - 24'h000001;
      default:  step_addr = a;
    endcase
  endfunction : step_addr

  // pick the request line that a trigger code names
  function automatic logic trig_pick(input logic [7:0] c,
                                     input dct_trig_req_t r);
    logic [7:0] off;
    logic [7:0] b;
    trig_pick = 1'b0;
    off = 8'h00;
    b = 8'h00;
    if (c == TRG_OFF) begin
      trig_pick = 1'b0;
    end else if (c >= TRG_EVT && c < TRG_EVT + N_EVT) begin
      off = c - TRG_EVT;
      trig_pick = MOD_PRESENT[0] & r.evt[off[1:0]];
    end else if (c == TRG_AES) begin
      trig_pick = MOD_PRESENT[1] & r.aes;
    end else if (c >= TRG_ADC1 && c <= TRG_ADC1 + N_ADC) begin
      off = c - TRG_ADC1;
      if (off == OFF_ADC_ALL)
        trig_pick = MOD_PRESENT[2] & (|r.adc1);
      else
        trig_pick = MOD_PRESENT[2] & r.adc1[off[1:0]];
    end else if (c >= TRG_DAC1 && c < TRG_DAC1 + N_DAC) begin
      off = c - TRG_DAC1;
      trig_pick = MOD_PRESENT[3] & r.dac1[off[0]];
    end else if (c >= TRG_ADC2 && c <= TRG_ADC2 + N_ADC) begin
      off = c - TRG_ADC2;
      if (off == OFF_ADC_ALL)
        trig_pick = MOD_PRESENT[4] & (|r.adc2);
      else
        trig_pick = MOD_PRESENT[4] & r.adc2[off[1:0]];
    end else if (c >= TRG_DAC2 && c < TRG_DAC2 + N_DAC) begin
      off = c - TRG_DAC2;
      trig_pick = MOD_PRESENT[5] & r.dac2[off[0]];
    end else begin
      for (int g = 0; g < 4; g++) begin
        b = PG_BASE0 + 8'(g) * PG_STRIDE;
        off = c - b;
        if (c >= b && PORT_PRESENT[g]) begin
          if (off < OFF_TMR0 + N_TMR0)
            trig_pick = r.port[g].tmr0[off[2:0]];
          else if (off >= OFF_TMR1 && off < OFF_TMR1 + N_TMR1)
            trig_pick = r.port[g].tmr1[2'(off - OFF_TMR1)];
          else if (off == OFF_SPI)
            trig_pick = r.port[g].spi;
          else if (off >= OFF_US0 && off < OFF_US0 + N_USART)
            trig_pick = r.port[g].usart0[1'(off - OFF_US0)];
          else if (off >= OFF_US1 && off < OFF_US1 + N_USART)
            trig_pick = r.port[g].usart1[1'(off - OFF_US1)];
        end
      end
    end
  endfunction : trig_pick

  // ****************************************************
  // ahb-lite slave
  // ****************************************************
  assign take  = hsel_in && htrans_in[1] && hready_in;
  assign wr_en = ap_q && ap_wr_q && ap_ok_q;
  assign wdata = hwdata_in[7:0];

  // address phase capture; only whole words are mapped
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      ap_q     <= 1'b0;
      ap_wr_q  <= 1'b0;
      ap_ok_q  <= 1'b0;
      ap_idx_q <= 8'h00;
    end else if (hready_in) begin
      ap_q     <= take;
      ap_wr_q  <= hwrite_in;
      ap_ok_q  <= (haddr_in[31:10] == 22'h000000) &&
                  (haddr_in[1:0] == 2'b00) && (hsize_in == 3'b010);
      ap_idx_q <= haddr_in[9:2];
    end
  end

  // reads take one wait state so hrdata comes from a flop
  // and sees any write finished in the cycle before
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      rd_wait_q <= 1'b0;
      hrdata_q  <= 8'h00;
    end else begin
      rd_wait_q <= ap_q && !ap_wr_q && !rd_wait_q;
      if (ap_q && !ap_wr_q && !rd_wait_q)
        hrdata_q <= ap_ok_q ? rd_val : 8'h00;
    end
  end

  assign hreadyout_out = !(ap_q && !ap_wr_q && !rd_wait_q);
  assign hresp_out     = 1'b0;
  assign hrdata_out    = {24'h000000, hrdata_q};

  // read mux; unmapped words read zero
  always_comb begin
    rd_val = 8'h00;
    if (ap_idx_q == IDX_CTRL) begin
      rd_val[CTRL_EN_BIT]  = en_q;
      rd_val[CTRL_REP_BIT] = rep_mode_q;
      rd_val[CTRL_SW_BIT]  = sw_pend_q;
    end else if (ap_idx_q == IDX_STAT) begin
      rd_val[STAT_BUSY] = !idle;
      rd_val[STAT_PEND] = idle && en_q && (sw_pend_q || hw_req);
    end else if (ap_idx_q == IDX_ADDRCTRL) begin
      rd_val[SRC_LSB +: 2] = src_step_q;
      rd_val[DST_LSB +: 2] = dst_step_q;
    end else if (ap_idx_q == IDX_TRIG) begin
      rd_val = trig_q;
    end else if (ap_idx_q == IDX_CNTL) begin
      rd_val = cnt_q[7:0];
    end else if (ap_idx_q == IDX_CNTH) begin
      rd_val = cnt_hold_q;
    end else if (ap_idx_q == IDX_REP) begin
      rd_val = rep_q;
    end else if (ap_idx_q == IDX_SA0) begin
      rd_val = sa_q[7:0];
    end else if (ap_idx_q == IDX_SA1) begin
      rd_val = sa_q[15:8];
    end else if (ap_idx_q == IDX_SA2) begin
      rd_val = sa_q[23:16];
    end
  end

  // reading the low count byte freezes the high byte
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in)
      cnt_hold_q <= CNT_RST[15:8];
    else if (ap_q && !ap_wr_q && !rd_wait_q && ap_idx_q == IDX_CNTL)
      cnt_hold_q <= cnt_q[15:8];
  end

  // ****************************************************
  // triggering
  // ****************************************************
  // flag level gated by its interrupt enable: a dropped flag
  // or a taken interrupt loses the request
  assign hw_req = trig_pick(trig_q, trig_req_in) &&
                  !req_irq_en_in;
  assign idle   = (state_q == ST_IDLE);
  assign start  = idle && en_q && (sw_pend_q || hw_req);
  assign rd_ack = (state_q == ST_READ) && mem_ack_in;

  // trigger select may change at any time
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in)
      trig_q <= TRIG_RST;
    else if (wr(IDX_TRIG))
      trig_q <= wdata;
  end

  // ****************************************************
  // control: enable, repeat mode, software trigger
  // ****************************************************
  // a software write wins over the hardware disable
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      en_q       <= 1'b0;
      rep_mode_q <= 1'b0;
      sw_pend_q  <= 1'b0;
    end else begin
      if (state_q == ST_DONE) begin
        if (!rep_mode_q)
          en_q <= 1'b0;
        else if (rep_q == 8'h01)
          en_q <= 1'b0;
      end
      if (start)
        sw_pend_q <= 1'b0;
      if (wr(IDX_CTRL)) begin
        en_q       <= wdata[CTRL_EN_BIT];
        rep_mode_q <= wdata[CTRL_REP_BIT];
        if (wdata[CTRL_SW_BIT])
          sw_pend_q <= 1'b1;
      end
    end
  end

  // step modes hold their value while busy
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      src_step_q <= STEP_FIXED;
      dst_step_q <= STEP_FIXED;
    end else if (wr(IDX_ADDRCTRL) && idle && !start) begin
      src_step_q <= dct_step_t'(wdata[SRC_LSB +: 2]);
      dst_step_q <= dct_step_t'(wdata[DST_LSB +: 2]);
    end
  end

  // ****************************************************
  // channel sequencer
  // ****************************************************
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start)
            state_q <= ST_READ;
        end
        ST_READ: begin
          if (mem_ack_in && cnt_q == 16'h0001)
            state_q <= ST_DONE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************
  // block byte count
  // ****************************************************
  // low byte parks in a holding flop until the high byte
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      cnt_tmp_q <= CNT_RST[7:0];
      cnt_rl_q  <= CNT_RST;
      cnt_q     <= CNT_RST;
    end else begin
      if (wr(IDX_CNTL))
        cnt_tmp_q <= wdata;
      if (wr(IDX_CNTH))
        cnt_rl_q <= {wdata, cnt_tmp_q};
      if (start && cnt_q == 16'h0000)
        cnt_q <= CNT_ZERO;
      else if (wr(IDX_CNTH) && idle && !start)
        cnt_q <= {wdata, cnt_tmp_q};
      else if (rd_ack)
        cnt_q <= cnt_q - 16'h0001;
      else if (state_q == ST_DONE)
        cnt_q <= cnt_rl_q;
    end
  end

  // ****************************************************
  // repeat counter
  // ****************************************************
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in)
      rep_q <= REP_RST;
    else if (wr(IDX_REP))
      rep_q <= wdata;
    else if (state_q == ST_DONE && rep_mode_q && rep_q != 8'h00)
      rep_q <= rep_q - 8'h01;
    // zero stays zero: endless repeat
  end

  // ****************************************************
  // source address
  // ****************************************************
  // top byte write commits all three bytes at once
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      sa_tmp_q <= ADDR_RST[15:0];
      sa_q     <= ADDR_RST;
    end else begin
      if (wr(IDX_SA0))
        sa_tmp_q[7:0] <= wdata;
      if (wr(IDX_SA1))
        sa_tmp_q[15:8] <= wdata;
      if (wr(IDX_SA2) && idle && !start)
        sa_q <= {wdata, sa_tmp_q};
      else if (rd_ack)
        sa_q <= step_addr(sa_q, src_step_q);
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  // acknowledge lets the peripheral clear its flag, so a
  // flag interrupt may never be seen by software
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      ack_q  <= 1'b0;
      code_q <= TRIG_RST;
      byte_q <= 1'b0;
      blk_q  <= 1'b0;
    end else begin
      ack_q  <= start && !sw_pend_q;
      if (start)
        code_q <= trig_q;
      byte_q <= rd_ack;
      blk_q  <= (state_q == ST_DONE);
    end
  end

  assign req_ack_out    = ack_q;
  assign req_code_out   = code_q;
  assign mem_rd_out     = (state_q == ST_READ);
  assign mem_addr_out   = sa_q;
  assign byte_done_out  = byte_q;
  assign dest_step_out  = dst_step_q;
  assign block_done_out = blk_q;
  assign busy_out       = !idle;
endmodule : dct_channel

// *** verilog/dct_pkg.sv ***
package dct_pkg;
  // ****************************************************
  // register indices (byte address = 4 * index)
  // ****************************************************
  localparam logic [7:0] IDX_CTRL     = 8'h00;
  localparam logic [7:0] IDX_STAT     = 8'h01;
  localparam logic [7:0] IDX_ADDRCTRL = 8'h02;
  localparam logic [7:0] IDX_TRIG     = 8'h03;
  localparam logic [7:0] IDX_CNTL     = 8'h04;
  localparam logic [7:0] IDX_CNTH     = 8'h05;
  localparam logic [7:0] IDX_REP      = 8'h06;
  localparam logic [7:0] IDX_SA0      = 8'h08;
  localparam logic [7:0] IDX_SA1      = 8'h09;
  localparam logic [7:0] IDX_SA2      = 8'h0A;

  // ****************************************************
  // field positions
  // ****************************************************
  localparam int CTRL_EN_BIT  = 7;
  localparam int CTRL_REP_BIT = 5;
  localparam int CTRL_SW_BIT  = 4;
  localparam int STAT_BUSY    = 7;
  localparam int STAT_PEND    = 6;
  localparam int SRC_LSB      = 4;
  localparam int DST_LSB      = 0;

  // ****************************************************
  // reset values and the zero-count load value
  // ****************************************************
  localparam logic [15:0] CNT_RST   = 16'h00FF;
  localparam logic [15:0] CNT_ZERO  = 16'hFFFF;
  localparam logic [7:0]  TRIG_RST  = 8'h00;
  localparam logic [7:0]  REP_RST   = 8'h00;
  localparam logic [23:0] ADDR_RST  = 24'h000000;

  // ****************************************************
  // trigger codes, offsets and group sizes
  // ****************************************************
  localparam logic [7:0] TRG_OFF   = 8'h00;
  localparam logic [7:0] TRG_EVT   = 8'h01;
  localparam logic [7:0] TRG_AES   = 8'h04;
  localparam logic [7:0] TRG_ADC1  = 8'h10;
  localparam logic [7:0] TRG_DAC1  = 8'h15;
  localparam logic [7:0] TRG_ADC2  = 8'h20;
  localparam logic [7:0] TRG_DAC2  = 8'h25;
  localparam logic [7:0] PG_BASE0  = 8'h40;
  localparam logic [7:0] PG_STRIDE = 8'h20;
  localparam logic [7:0] OFF_TMR0  = 8'h00;
  localparam logic [7:0] OFF_TMR1  = 8'h06;
  localparam logic [7:0] OFF_SPI   = 8'h0A;
  localparam logic [7:0] OFF_US0   = 8'h0B;
  localparam logic [7:0] OFF_US1   = 8'h0E;
  localparam logic [7:0] OFF_ADC_ALL = 8'h04;
  localparam logic [7:0] N_EVT     = 8'h03;
  localparam logic [7:0] N_ADC     = 8'h04;
  localparam logic [7:0] N_DAC     = 8'h02;
  localparam logic [7:0] N_TMR0    = 8'h06;
  localparam logic [7:0] N_TMR1    = 8'h04;
  localparam logic [7:0] N_USART   = 8'h02;

  // ****************************************************
  // types
  // ****************************************************
  typedef enum logic [1:0] {
    STEP_FIXED = 2'b00, STEP_INC = 2'b01,
    STEP_DEC = 2'b10, STEP_RSVD = 2'b11
  } dct_step_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_READ = 2'b01, ST_DONE = 2'b10
  } dct_state_t;

  // bit index inside each vector equals the request offset
  typedef struct packed {
    logic [1:0] usart1;
    logic [1:0] usart0;
    logic       spi;
    logic [3:0] tmr1;
    logic [5:0] tmr0;
  } dct_port_req_t;

  typedef struct packed {
    dct_port_req_t [3:0] port;
    logic [1:0] dac2;
    logic [3:0] adc2;
    logic [1:0] dac1;
    logic [3:0] adc1;
    logic       aes;
    logic [2:0] evt;
  } dct_trig_req_t;
endpackage : dct_pkg
